// ===== shared/mcs_pkg.sv
/*
 Constants, types and register layout for the memory, cache and shadow
 configuration bank. Assumes an 8-bit indexed register port.
*/
package mcs_pkg;
  localparam int unsigned IDX_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned MEM_AW = 32;

  localparam logic [7:0] IDX_CACHE_PARITY = 8'h21;
  localparam logic [7:0] IDX_ROM_SHADOW = 8'h22;
  localparam logic [7:0] IDX_SEG_SHADOW = 8'h23;
  localparam logic [7:0] IDX_DRAM_CFG = 8'h24;

  localparam logic [7:0] CACHE_PARITY_RST = 8'h00;
  localparam logic [7:0] ROM_SHADOW_RST = 8'hE4;
  localparam logic [7:0] SEG_SHADOW_RST = 8'h00;
  localparam logic [7:0] DRAM_CFG_RST = 8'h00;

  localparam int unsigned CP_BYTE_SWAP = 7;
  localparam int unsigned CP_PARITY_DIS = 5;
  localparam int unsigned CP_L2_EN = 4;
  localparam int unsigned CP_SIZE_LO = 2;
  localparam int unsigned CP_WR_LEADOFF = 1;
  localparam int unsigned CP_RD_LEADOFF = 0;

  localparam int unsigned RS_ROM_SEL = 7;
  localparam int unsigned RS_WP_D = 4;
  localparam int unsigned RS_WP_E = 3;
  localparam int unsigned RS_REF_CONV = 2;
  localparam int unsigned RS_FAST_A20 = 1;
  localparam int unsigned RS_SLOW_REF = 0;

  localparam int unsigned SS_E_LO = 4;
  localparam int unsigned SS_D_LO = 0;

  localparam int unsigned DC_SMI_UPLOAD = 7;
  localparam int unsigned DC_CFG_HI_LO = 4;
  localparam int unsigned DC_CFG_LO_LO = 0;

  localparam int unsigned SEG_HI = 19;
  localparam int unsigned SLICE_HI = 15;
  localparam logic [3:0] SEG_F = 4'hF;
  localparam logic [3:0] SEG_E = 4'hE;
  localparam logic [3:0] SEG_D = 4'hD;
  localparam logic [3:0] SEG_SMI_SRC = 4'h3;
  localparam logic [3:0] SEG_SMI_DST = 4'hB;
  localparam logic [11:0] LOW_MEG = 12'h000;

  localparam logic [1:0] LEADOFF_SLOW_CLKS = 2'h3;
  localparam logic [1:0] LEADOFF_FAST_CLKS = 2'h2;
  localparam logic [1:0] BURST_FAST_CLKS = 2'h1;
  localparam logic [1:0] BURST_SLOW_CLKS = 2'h2;

  localparam logic [1:0] SLOW_REF_LAST = 2'h3;

  typedef struct packed {
    logic enable;
    logic [1:0] size;
    logic [1:0] rd_first_clks;
    logic [1:0] wr_first_clks;
    logic [1:0] burst_clks;
  } mcs_cache_cfg_t;

  typedef struct packed {
    logic to_rom;
    logic to_dram;
    logic to_isa;
    logic wr_dropped;
  } mcs_route_t;

  typedef enum logic [1:0] {
    REF_IDLE = 2'b00,
    REF_HOLD = 2'b01,
    REF_RUN = 2'b11,
    REF_END = 2'b10
  } mcs_ref_state_t;
endpackage : mcs_pkg

// ===== core/mcs_config_regs.sv
/*
 Memory, cache, shadow and refresh configuration bank with its decode:
 four indexed registers, memory cycle routing, refresh hold control and
 the address-20 mask. Assumes a one-cycle register port, memory cycles
 presented as single-cycle valid pulses, and a DRAM controller that
 reports the end of each refresh.
*/
// Overview of operation
// - Control bit7 enables byte swap; bit6 reserved; bit5 high disables parity check.
// - Bit1 sets write leadoff 3 or 2 clocks; bit4 cache enable; bits3:2 size.
// - Bit0 sets read leadoff: 0 gives three clocks, 1 gives two clocks.
// - F segment: 1 reads ROM with select, writes DRAM; 0 protected DRAM.
// - Shadow bit4 makes the D segment shadow read only.
// - Shadow bit3 makes the E segment shadow read only.
// - Refresh type 0 refreshes DRAM without raising hold to the processor.
// - Refresh type 1, default, raises hold for each whole refresh.
// - Fast gate bit holds address-20 mask high, else keyboard logic drives it.
// - Slow refresh bit refreshes at one quarter rate; only for capable DRAMs.
// - Segment bits 7:4 shadow E segment 16KB slices, clear forwards to ISA.
// - Segment bits 3:0 shadow D segment 16KB slices, clear forwards to ISA.
// - Upload bit remaps 3XXXX to BXXXX for loading the handler.
// - DRAM register holds two 3-bit bank codes, bits 6:4 and 2:0.
// - Leadoff bits time first burst transfer; burst bit times the rest.
`timescale 1ns/1ns
`default_nettype none
module mcs_config_regs (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic burst_ws_in,
  input wire logic mem_valid_in,
  input wire logic mem_write_in,
  input wire logic [31:0] mem_addr_in,
  output logic mem_valid_out,
  output logic [31:0] mem_addr_out,
  output mcs_pkg::mcs_route_t route_out,
  output logic rom_chip_select_n_out,
  output mcs_pkg::mcs_cache_cfg_t cache_cfg_out,
  output logic byte_swap_en_out,
  output logic parity_check_en_out,
  output logic [2:0] dram_cfg_hi_out,
  output logic [2:0] dram_cfg_lo_out,
  output logic smi_upload_out,
  input wire logic refresh_tick_in,
  input wire logic hold_ack_in,
  input wire logic refresh_done_in,
  output logic refresh_start_out,
  output logic hold_req_out,
  input wire logic kbd_a20_gate_in,
  output logic addr20_mask_n_out
);
  logic [7:0] cp_q, cp_d;
  logic [7:0] rs_q, rs_d;
  logic [7:0] ss_q, ss_d;
  logic [7:0] dc_q, dc_d;
  logic [7:0] rdata_q, rdata_d;

  // Register writes; reserved bits are stored as written
  always_comb begin
    cp_d = cp_q;
    rs_d = rs_q;
    ss_d = ss_q;
    dc_d = dc_q;
    if (reg_wr_in) begin
      case (reg_addr_in)
        mcs_pkg::IDX_CACHE_PARITY: cp_d = reg_wdata_in;
        mcs_pkg::IDX_ROM_SHADOW: rs_d = reg_wdata_in;
        mcs_pkg::IDX_SEG_SHADOW: ss_d = reg_wdata_in;
        mcs_pkg::IDX_DRAM_CFG: dc_d = reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Read data valid only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd_in) begin
      case (reg_addr_in)
        mcs_pkg::IDX_CACHE_PARITY: rdata_d = cp_q;
        mcs_pkg::IDX_ROM_SHADOW: rdata_d = rs_q;
        mcs_pkg::IDX_SEG_SHADOW: rdata_d = ss_q;
        mcs_pkg::IDX_DRAM_CFG: rdata_d = dc_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cp_q <= mcs_pkg::CACHE_PARITY_RST;
      rs_q <= mcs_pkg::ROM_SHADOW_RST;
      ss_q <= mcs_pkg::SEG_SHADOW_RST;
      dc_q <= mcs_pkg::DRAM_CFG_RST;
      rdata_q <= 8'h00;
    end else begin
      cp_q <= cp_d;
      rs_q <= rs_d;
      ss_q <= ss_d;
      dc_q <= dc_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // Static configuration straight from register flops
  assign byte_swap_en_out = cp_q[mcs_pkg::CP_BYTE_SWAP];
  assign parity_check_en_out = ~cp_q[mcs_pkg::CP_PARITY_DIS];
  assign dram_cfg_hi_out = dc_q[mcs_pkg::DC_CFG_HI_LO +: 3];
  assign dram_cfg_lo_out = dc_q[mcs_pkg::DC_CFG_LO_LO +: 3];
  assign smi_upload_out = dc_q[mcs_pkg::DC_SMI_UPLOAD];

  // Cache timing: clocks for first transfer and for each later one
  mcs_pkg::mcs_cache_cfg_t cache_q, cache_d;

  always_comb begin
    cache_d.enable = cp_q[mcs_pkg::CP_L2_EN];
    cache_d.size = cp_q[mcs_pkg::CP_SIZE_LO +: 2];
    cache_d.wr_first_clks = cp_q[mcs_pkg::CP_WR_LEADOFF] ?
      mcs_pkg::LEADOFF_FAST_CLKS : mcs_pkg::LEADOFF_SLOW_CLKS;
    cache_d.rd_first_clks = cp_q[mcs_pkg::CP_RD_LEADOFF] ?
      mcs_pkg::LEADOFF_FAST_CLKS : mcs_pkg::LEADOFF_SLOW_CLKS;
    cache_d.burst_clks = burst_ws_in ?
      mcs_pkg::BURST_SLOW_CLKS : mcs_pkg::BURST_FAST_CLKS;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cache_q <= '{1'b0, 2'h0, mcs_pkg::LEADOFF_SLOW_CLKS,
                   mcs_pkg::LEADOFF_SLOW_CLKS, mcs_pkg::BURST_FAST_CLKS};
    end else begin
      cache_q <= cache_d;
    end
  end

  assign cache_cfg_out = cache_q;

  // Memory cycle routing for the low megabyte windows
  mcs_pkg::mcs_route_t route_q, route_d;
  logic [31:0] maddr_q, maddr_d;
  logic mvalid_q, mvalid_d;
  logic rom_chip_select_n_n_q, rom_chip_select_n_n_d;
  logic low_meg;
  logic [3:0] seg;
  logic [1:0] slice;
  logic shadow_on;
  logic wp_on;

  always_comb begin
    low_meg = (mem_addr_in[mcs_pkg::MEM_AW-1:mcs_pkg::SEG_HI+1] == mcs_pkg::LOW_MEG);
    seg = mem_addr_in[mcs_pkg::SEG_HI -: 4];
    slice = mem_addr_in[mcs_pkg::SLICE_HI -: 2];
    shadow_on = 1'b0;
    wp_on = 1'b0;
    maddr_d = mem_addr_in;
    route_d = '{1'b0, 1'b1, 1'b0, 1'b0};
    rom_chip_select_n_n_d = 1'b1;
    mvalid_d = mem_valid_in;
    if (low_meg) begin
      case (seg)
        mcs_pkg::SEG_F: begin
          if (rs_q[mcs_pkg::RS_ROM_SEL]) begin
            route_d.to_rom = ~mem_write_in;
            route_d.to_dram = mem_write_in;
            rom_chip_select_n_n_d = mem_write_in | ~mem_valid_in;
          end else begin
            route_d.wr_dropped = mem_write_in;
            route_d.to_dram = ~mem_write_in;
          end
        end
        mcs_pkg::SEG_E, mcs_pkg::SEG_D: begin
          if (seg == mcs_pkg::SEG_E) begin
            shadow_on = ss_q[mcs_pkg::SS_E_LO + 32'(slice)];
            wp_on = rs_q[mcs_pkg::RS_WP_E];
          end else begin
            shadow_on = ss_q[mcs_pkg::SS_D_LO + 32'(slice)];
            wp_on = rs_q[mcs_pkg::RS_WP_D];
          end
          if (!shadow_on) begin
            route_d.to_dram = 1'b0;
            route_d.to_isa = 1'b1;
          end else if (mem_write_in && wp_on) begin
            route_d.to_dram = 1'b0;
            route_d.wr_dropped = 1'b1;
          end
        end
        mcs_pkg::SEG_SMI_SRC: begin
          if (dc_q[mcs_pkg::DC_SMI_UPLOAD]) begin
            maddr_d[mcs_pkg::SEG_HI -: 4] = mcs_pkg::SEG_SMI_DST;
          end
        end
        default: ;
      endcase
    end
    if (!mem_valid_in) begin
      route_d = '{1'b0, 1'b0, 1'b0, 1'b0};
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      route_q <= '{1'b0, 1'b0, 1'b0, 1'b0};
      maddr_q <= 32'h0000_0000;
      mvalid_q <= 1'b0;
      rom_chip_select_n_n_q <= 1'b1;
    end else begin
      route_q <= route_d;
      maddr_q <= maddr_d;
      mvalid_q <= mvalid_d;
      rom_chip_select_n_n_q <= rom_chip_select_n_n_d;
    end
  end

  assign route_out = route_q;
  assign mem_addr_out = maddr_q;
  assign mem_valid_out = mvalid_q;
  assign rom_chip_select_n_out = rom_chip_select_n_n_q;

  // Refresh request divider, pending flag and hold sequencing
  mcs_pkg::mcs_ref_state_t ref_q, ref_d;
  logic [1:0] div_q, div_d;
  logic pend_q, pend_d;
  logic conv_q, conv_d;
  logic start_q, start_d;
  logic hold_q, hold_d;
  logic tick_ok;
  logic take;

  always_comb begin
    div_d = div_q;
    tick_ok = 1'b0;
    if (refresh_tick_in) begin
      if (rs_q[mcs_pkg::RS_SLOW_REF]) begin
        div_d = div_q + 2'h1;
        tick_ok = (div_q == mcs_pkg::SLOW_REF_LAST);
      end else begin
        div_d = 2'h0;
        tick_ok = 1'b1;
      end
    end
    take = (ref_q == mcs_pkg::REF_IDLE) && pend_q;
    // A new tick in the taking cycle stays pending
    pend_d = (pend_q & ~take) | tick_ok;
    ref_d = ref_q;
    conv_d = conv_q;
    start_d = 1'b0;
    case (ref_q)
      mcs_pkg::REF_IDLE: begin
        if (take) begin
          conv_d = rs_q[mcs_pkg::RS_REF_CONV];
          if (rs_q[mcs_pkg::RS_REF_CONV]) begin
            ref_d = mcs_pkg::REF_HOLD;
          end else begin
            ref_d = mcs_pkg::REF_RUN;
            start_d = 1'b1;
          end
        end
      end
      mcs_pkg::REF_HOLD: begin
        if (hold_ack_in) begin
          ref_d = mcs_pkg::REF_RUN;
          start_d = 1'b1;
        end
      end
      mcs_pkg::REF_RUN: begin
        if (refresh_done_in && !start_q) begin
          ref_d = mcs_pkg::REF_END;
        end
      end
      mcs_pkg::REF_END: ref_d = mcs_pkg::REF_IDLE;
      default: ref_d = mcs_pkg::REF_IDLE;
    endcase
    hold_d = conv_d && (ref_d == mcs_pkg::REF_HOLD || ref_d == mcs_pkg::REF_RUN);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ref_q <= mcs_pkg::REF_IDLE;
      div_q <= 2'h0;
      pend_q <= 1'b0;
      conv_q <= 1'b0;
      start_q <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      ref_q <= ref_d;
      div_q <= div_d;
      pend_q <= pend_d;
      conv_q <= conv_d;
      start_q <= start_d;
      hold_q <= hold_d;
    end
  end

  assign refresh_start_out = start_q;
  assign hold_req_out = hold_q;

  // Address-20 mask: forced high or following keyboard emulation
  logic a20_q, a20_d;

  always_comb begin
    a20_d = rs_q[mcs_pkg::RS_FAST_A20] ? 1'b1 : kbd_a20_gate_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      a20_q <= 1'b1;
    end else begin
      a20_q <= a20_d;
    end
  end

  assign addr20_mask_n_out = a20_q;
endmodule : mcs_config_regs
`default_nettype wire

// ===== tb/mcs_config_regs_monitor.sv
/*
 Port checker for the configuration bank.
 Assumes it is bound to mcs_config_regs, one clock, reset active low.
*/
`timescale 1ns/1ns
`default_nettype none
module mcs_config_regs_monitor (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic burst_ws_in,
  input wire logic mem_valid_in,
  input wire logic mem_write_in,
  input wire logic [31:0] mem_addr_in,
  input wire logic mem_valid_out,
  input wire logic [31:0] mem_addr_out,
  input wire mcs_pkg::mcs_route_t route_out,
  input wire logic rom_chip_select_n_out,
  input wire mcs_pkg::mcs_cache_cfg_t cache_cfg_out,
  input wire logic byte_swap_en_out,
  input wire logic parity_check_en_out,
  input wire logic [2:0] dram_cfg_hi_out,
  input wire logic [2:0] dram_cfg_lo_out,
  input wire logic smi_upload_out,
  input wire logic refresh_done_in,
  input wire logic refresh_start_out,
  input wire logic hold_req_out,
  input wire logic kbd_a20_gate_in,
  input wire logic addr20_mask_n_out
);
  logic [7:0] cp_q, cp_d, rs_q, rs_d, dc_q, dc_d;

  // Own copies of the control, shadow and DRAM registers
  always_comb begin
    cp_d = cp_q;
    rs_d = rs_q;
    dc_d = dc_q;
    if (reg_wr_in && reg_addr_in == 8'h21) cp_d = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == 8'h22) rs_d = reg_wdata_in;
    if (reg_wr_in && reg_addr_in == 8'h24) dc_d = reg_wdata_in;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cp_q <= 8'h00;
      rs_q <= 8'hE4;
      dc_q <= 8'h00;
    end else begin
      cp_q <= cp_d;
      rs_q <= rs_d;
      dc_q <= dc_d;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);

  rdata_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  rdata_shadow_a: assert property (reg_rd_in && reg_addr_in == 8'h22 |=>
    reg_rdata_out == $past(rs_q)) else $error("shadow register read back wrong");
  cache_timing_a: assert property ($past(rstn_in) |-> cache_cfg_out.enable == $past(cp_q[4])
    && cache_cfg_out.size == $past(cp_q[3:2])
    && cache_cfg_out.rd_first_clks == ($past(cp_q[0]) ? 2'h2 : 2'h3)
    && cache_cfg_out.wr_first_clks == ($past(cp_q[1]) ? 2'h2 : 2'h3)
    && cache_cfg_out.burst_clks == ($past(burst_ws_in) ? 2'h2 : 2'h1))
    else $error("cache timing outputs wrong");
  cpu_ctrl_a: assert property (byte_swap_en_out == cp_q[7] &&
    parity_check_en_out == !cp_q[5]) else $error("swap or parity enable wrong");
  dram_ctrl_a: assert property (dram_cfg_hi_out == dc_q[6:4] && dram_cfg_lo_out == dc_q[2:0]
    && smi_upload_out == dc_q[7]) else $error("dram config outputs wrong");
  a20_gate_a: assert property ($past(rstn_in) |->
    addr20_mask_n_out == ($past(rs_q[1]) | $past(kbd_a20_gate_in))) else $error("a20 mask wrong");
  rom_select_a: assert property (mem_valid_in && !mem_write_in && mem_addr_in[31:16] == 16'h000F
    && rs_q[7] |=> !rom_chip_select_n_out && route_out.to_rom) else $error("rom read not selected");
  route_idle_a: assert property (!mem_valid_in |=> route_out == 4'h0 && !mem_valid_out
    && rom_chip_select_n_out) else $error("route active without a cycle");
  smi_remap_a: assert property (mem_valid_in && dc_q[7] && mem_addr_in[31:16] == 16'h0003
    |=> mem_addr_out == {16'h000B, $past(mem_addr_in[15:0])} && route_out.to_dram)
    else $error("upload remap wrong");
  hold_conv_a: assert property (refresh_start_out && rs_q[2] |-> hold_req_out)
    else $error("conventional refresh without hold");
  refresh_hidden_a: assert property (refresh_start_out && !rs_q[2] |-> !hold_req_out)
    else $error("hidden refresh raised hold");
  hold_release_a: assert property (refresh_done_in && hold_req_out && !refresh_start_out
    |=> !hold_req_out) else $error("hold not released after refresh");
endmodule : mcs_config_regs_monitor
`default_nettype wire

// ===== tb/mcs_config_regs_tb.sv
/*
 Self-checking bench for the configuration bank.
 Assumes the package and design are compiled first; drives all ports itself.
*/
`timescale 1ns/1ns
`default_nettype none
module mcs_config_regs_tb;
  logic clk_in, rstn_in, reg_wr_in, reg_rd_in, burst_ws_in, mem_valid_in, mem_write_in;
  logic refresh_tick_in, hold_ack_in, refresh_done_in, kbd_a20_gate_in;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [31:0] mem_addr_in, mem_addr_out, a;
  logic mem_valid_out, rom_chip_select_n_out, byte_swap_en_out, parity_check_en_out;
  logic smi_upload_out, refresh_start_out, hold_req_out, addr20_mask_n_out;
  logic [2:0] dram_cfg_hi_out, dram_cfg_lo_out;
  mcs_pkg::mcs_route_t route_out;
  mcs_pkg::mcs_cache_cfg_t cache_cfg_out;
  int errors, checked, starts, s;
  logic [7:0] dflt [4] = '{8'h00, 8'hE4, 8'h00, 8'h00};
  // Write values keep every reserved bit at its required level
  logic [7:0] vals [4] = '{8'hA5, 8'hE6, 8'hA7, 8'h25};

  mcs_config_regs i_mcs_config_regs (.clk_in(clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .burst_ws_in(burst_ws_in),
    .mem_valid_in(mem_valid_in), .mem_write_in(mem_write_in), .mem_addr_in(mem_addr_in),
    .mem_valid_out(mem_valid_out), .mem_addr_out(mem_addr_out), .route_out(route_out),
    .rom_chip_select_n_out(rom_chip_select_n_out), .cache_cfg_out(cache_cfg_out),
    .byte_swap_en_out(byte_swap_en_out), .parity_check_en_out(parity_check_en_out),
    .dram_cfg_hi_out(dram_cfg_hi_out), .dram_cfg_lo_out(dram_cfg_lo_out),
    .smi_upload_out(smi_upload_out), .refresh_tick_in(refresh_tick_in),
    .hold_ack_in(hold_ack_in), .refresh_done_in(refresh_done_in),
    .refresh_start_out(refresh_start_out), .hold_req_out(hold_req_out),
    .kbd_a20_gate_in(kbd_a20_gate_in), .addr20_mask_n_out(addr20_mask_n_out));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic settle;
    repeat (2) @(posedge clk_in);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'h1;
    @(posedge clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'h1;
    @(posedge clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk(reg_rdata_out, exp);
  endtask : rd

  // One memory cycle; m masks route bits left open for dropped writes
  task automatic mem(input logic w, input logic [31:0] ad, input logic [31:0] ea,
                     input logic [3:0] er, input logic [3:0] m);
    @(posedge clk_in);
    mem_valid_in <= 1'h1;
    mem_write_in <= w;
    mem_addr_in <= ad;
    @(posedge clk_in);
    mem_valid_in <= 1'h0;
    #1;
    chk(route_out & m, er);
    chk(mem_addr_out, ea);
    chk(rom_chip_select_n_out, !er[3]);
    chk(mem_valid_out, 1'h1);
  endtask : mem

  // Tick, then finish any refresh that started
  task automatic rtick;
    int s0;
    s0 = starts;
    @(posedge clk_in);
    refresh_tick_in <= 1'h1;
    @(posedge clk_in);
    refresh_tick_in <= 1'h0;
    repeat (5) @(posedge clk_in);
    if (starts != s0) begin
      refresh_done_in <= 1'h1;
      @(posedge clk_in);
      refresh_done_in <= 1'h0;
    end
    repeat (3) @(posedge clk_in);
  endtask : rtick

  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  always @(posedge clk_in) if (refresh_start_out) starts++;

  initial begin
    repeat (100000) @(posedge clk_in);
    errors++;
    $display("MISMATCH t=%0t run did not finish", $time);
    stop_test();
  end

  initial begin
    {rstn_in, reg_wr_in, reg_rd_in, burst_ws_in, mem_valid_in, mem_write_in} = 6'h00;
    {refresh_tick_in, hold_ack_in, refresh_done_in, kbd_a20_gate_in} = 4'h0;
    {reg_addr_in, reg_wdata_in, mem_addr_in} = 48'h0;
    repeat (20) @(posedge clk_in);
    rstn_in <= 1'h1;
    for (int i = 0; i < 4; i++) rd(8'(8'h21 + i), dflt[i]);
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'h21 + i), vals[i]);
      rd(8'(8'h21 + i), vals[i]);
    end
    wr(8'h25, 8'hFF);
    rd(8'h25, 8'h00);
    rd(8'h21, 8'hA5);
    @(posedge clk_in) burst_ws_in <= 1'h1;
    wr(8'h21, 8'hB7);
    settle();
    chk(cache_cfg_out, {1'h1, 2'h1, 2'h2, 2'h2, 2'h2});
    chk({byte_swap_en_out, parity_check_en_out}, 2'h2);
    @(posedge clk_in) burst_ws_in <= 1'h0;
    wr(8'h21, 8'h08);
    settle();
    chk(cache_cfg_out, {1'h0, 2'h2, 2'h3, 2'h3, 2'h1});
    chk({byte_swap_en_out, parity_check_en_out}, 2'h1);
    wr(8'h24, 8'h35);
    settle();
    chk({smi_upload_out, dram_cfg_hi_out, dram_cfg_lo_out}, 7'h1D);
    wr(8'h22, 8'hE4);
    mem(1'h0, 32'hF1234, 32'hF1234, 4'h8, 4'hF);
    mem(1'h1, 32'hF1234, 32'hF1234, 4'h4, 4'hF);
    wr(8'h22, 8'h64);
    mem(1'h0, 32'hF1234, 32'hF1234, 4'h4, 4'hF);
    mem(1'h1, 32'hF1234, 32'hF1234, 4'h1, 4'hB);
    wr(8'h22, 8'hE4);
    for (int i = 0; i < 8; i++) begin
      wr(8'h23, 8'(1 << i));
      a = 32'hD0000 + 32'(i) * 32'h4000;
      mem(1'h0, a, a, 4'h4, 4'hF);
      mem(1'h0, a ^ 32'h4000, a ^ 32'h4000, 4'h2, 4'hF);
    end
    wr(8'h23, 8'hFF);
    wr(8'h22, 8'hF4);
    mem(1'h1, 32'hD0000, 32'hD0000, 4'h1, 4'hB);
    mem(1'h0, 32'hD0000, 32'hD0000, 4'h4, 4'hF);
    mem(1'h1, 32'hE0000, 32'hE0000, 4'h4, 4'hF);
    wr(8'h22, 8'hEC);
    mem(1'h1, 32'hE8000, 32'hE8000, 4'h1, 4'hB);
    mem(1'h1, 32'hD8000, 32'hD8000, 4'h4, 4'hF);
    wr(8'h24, 8'h80);
    mem(1'h1, 32'h31234, 32'hB1234, 4'h4, 4'hF);
    mem(1'h0, 32'h1F1234, 32'h1F1234, 4'h4, 4'hF);
    wr(8'h24, 8'h00);
    mem(1'h1, 32'h31234, 32'h31234, 4'h4, 4'hF);
    wr(8'h22, 8'hE4);
    kbd_a20_gate_in <= 1'h1;
    settle();
    chk(addr20_mask_n_out, 1'h1);
    @(posedge clk_in) kbd_a20_gate_in <= 1'h0;
    settle();
    chk(addr20_mask_n_out, 1'h0);
    wr(8'h22, 8'hE6);
    settle();
    chk(addr20_mask_n_out, 1'h1);
    s = starts;
    rtick();
    chk(hold_req_out, 1'h1);
    chk(starts, s);
    hold_ack_in <= 1'h1;
    repeat (4) @(posedge clk_in);
    chk(starts, s + 1);
    refresh_done_in <= 1'h1;
    @(posedge clk_in);
    refresh_done_in <= 1'h0;
    hold_ack_in <= 1'h0;
    settle();
    chk(hold_req_out, 1'h0);
    wr(8'h22, 8'hE0);
    s = starts;
    rtick();
    chk(starts, s + 1);
    wr(8'h22, 8'hE1);
    s = starts;
    repeat (8) rtick();
    chk(starts, s + 2);
    stop_test();
  end
endmodule : mcs_config_regs_tb

bind mcs_config_regs mcs_config_regs_monitor i_mcs_config_regs_monitor (.clk_in(clk_in),
  .rstn_in(rstn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .burst_ws_in(burst_ws_in), .mem_valid_in(mem_valid_in), .mem_write_in(mem_write_in),
  .mem_addr_in(mem_addr_in), .mem_valid_out(mem_valid_out), .mem_addr_out(mem_addr_out),
  .route_out(route_out), .rom_chip_select_n_out(rom_chip_select_n_out),
  .cache_cfg_out(cache_cfg_out), .byte_swap_en_out(byte_swap_en_out),
  .parity_check_en_out(parity_check_en_out), .dram_cfg_hi_out(dram_cfg_hi_out),
  .dram_cfg_lo_out(dram_cfg_lo_out), .smi_upload_out(smi_upload_out),
  .refresh_done_in(refresh_done_in), .refresh_start_out(refresh_start_out),
  .hold_req_out(hold_req_out), .kbd_a20_gate_in(kbd_a20_gate_in),
  .addr20_mask_n_out(addr20_mask_n_out));
`default_nettype wire
